/* verilog/acx_core.sv */
`timescale 1ns/100ps
`include "acx_defines.svh"
module acx_core
	import acx_pkg::*;
(
	// Clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        SYS_RST,
	// Configuration from the surrounding core
	input  wire logic [3:0]  WORK_GROUP,
	input  wire logic        STACK_EXT,
	// Program memory
	output logic      [15:0] PM_ADDR,
	output logic             PM_RD,
	input  wire logic [7:0]  PM_RDATA,
	// Register file, two read ports and one write port
	output logic      [7:0]  RF_RADDR_A,
	output logic      [7:0]  RF_RADDR_B,
	output logic             RF_RD,
	input  wire logic [7:0]  RF_RDATA_A,
	input  wire logic [7:0]  RF_RDATA_B,
	output logic      [7:0]  RF_WADDR,
	output logic             RF_WE,
	output logic      [7:0]  RF_WDATA,
	// External data memory
	output logic      [15:0] DM_ADDR,
	output logic             DM_RD,
	output logic             DM_WE,
	output logic      [7:0]  DM_WDATA,
	input  wire logic [7:0]  DM_RDATA,
	// Core state
	output logic      [15:0] PC,
	output logic      [15:0] SP,
	output acx_flags_s       FLAGS,
	output logic             INSTR_DONE
);

	acx_state_e state_ff, nxt_state;
	logic [7:0]  cnt_ff, nxt_cnt;
	logic [7:0]  op_ff, nxt_op;
	logic [7:0]  b1_ff, nxt_b1;
	logic [7:0]  b2_ff, nxt_b2;
	logic [7:0]  dst_eff_ff, nxt_dst_eff;
	logic [15:0] pc_ff, nxt_pc;
	logic [15:0] sp_ff, nxt_sp;
	acx_flags_s  flags_ff, nxt_flags;
	logic [15:0] pm_addr_ff, nxt_pm_addr;
	logic        pm_rd_ff, nxt_pm_rd;
	logic [7:0]  rf_raddr_a_ff, nxt_rf_raddr_a;
	logic [7:0]  rf_raddr_b_ff, nxt_rf_raddr_b;
	logic        rf_rd_ff, nxt_rf_rd;
	logic [7:0]  rf_waddr_ff, nxt_rf_waddr;
	logic        rf_we_ff, nxt_rf_we;
	logic [7:0]  rf_wdata_ff, nxt_rf_wdata;
	logic [15:0] dm_addr_ff, nxt_dm_addr;
	logic        dm_rd_ff, nxt_dm_rd;
	logic        dm_we_ff, nxt_dm_we;
	logic [7:0]  dm_wdata_ff, nxt_dm_wdata;
	logic        done_ff, nxt_done;

	acx_dec_s    dec;
	logic [7:0]  dst_addr;
	logic [7:0]  src_addr;
	logic [7:0]  pair_addr;
	logic [7:0]  target;
	logic [15:0] sp_pushed;
	logic        alu_go;
	logic [7:0]  alu_b;
	logic [7:0]  alu_sum;
	acx_flags_s  alu_flg;

	// A full register byte with Eh on top names a working register of the current group.
	function automatic logic [7:0] acx_resolve(input logic [7:0] b, input logic [3:0] grp);
		acx_resolve = (b[7:4] == `WORK_NIB) ? {grp, b[3:0]} : b;
	endfunction

	function automatic acx_dec_s acx_decode(input logic [7:0] op);
		acx_dec_s d;
		d        = '0;
		d.len    = `LEN_ONE;
		d.cycles = `CYC_OTHER;
		if ((op[7:4] == `OP_ADD_NIB || op[7:4] == `OP_ADC_NIB) &&
		    op[3:0] >= `MODE_WORK_WORK && op[3:0] <= `MODE_IND_IMM) begin
			d.add                       = 1'b1;
			d.adc                       = (op[7:4] == `OP_ADC_NIB);
			d.nib_regs                  = (op[3:0] <= `MODE_WORK_IND);
			d.two_full                  = (op[3:0] == `MODE_FULL_FULL) ||
			                              (op[3:0] == `MODE_FULL_IND);
			d.indirect_working_reg_mode = (op[3:0] == `MODE_WORK_IND);
			d.indirect_full_reg_mode    = (op[3:0] == `MODE_FULL_IND);
			d.dst_ind                   = (op[3:0] == `MODE_IND_IMM);
			d.immediate_mode            = (op[3:0] >= `MODE_FULL_IMM);
			d.len                       = d.nib_regs ? `LEN_TWO : `LEN_THREE;
			d.cycles                    = d.nib_regs ? `CYC_SHORT : `CYC_LONG;
		end else if (op == `OP_CALL_DIRECT) begin
			d.direct_address_mode = 1'b1;
			d.len                 = `LEN_THREE;
			d.cycles              = `CYC_CALL;
		end else if (op == `OP_CALL_PAIR) begin
			d.call_pair = 1'b1;
			d.len       = `LEN_TWO;
			d.cycles    = `CYC_CALL;
		end else if (op == `SUBROUTINE_RETURN_OP) begin
			d.subroutine_return_op = 1'b1;
			d.cycles               = `CYC_POP;
		end
		acx_decode = d;
	endfunction

	acx_adder u_adder (
		.clk    (REF_CLK),
		.rst    (SYS_RST),
		.go     (alu_go),
		.a      (RF_RDATA_A),
		.b      (alu_b),
		.cin    (dec.adc & flags_ff.c),
		.sum_ff (alu_sum),
		.flg_ff (alu_flg)
	);

	always_comb begin
		dec       = acx_decode(op_ff);
		// Full two-register forms carry the source byte ahead of the destination byte; working pairs share one byte, destination nibble on top.
		src_addr  = dec.nib_regs ? {WORK_GROUP, b1_ff[3:0]} : acx_resolve(b1_ff, WORK_GROUP);
		dst_addr  = dec.nib_regs ? {WORK_GROUP, b1_ff[7:4]} :
		            dec.two_full ? acx_resolve(b2_ff, WORK_GROUP) :
		            acx_resolve(b1_ff, WORK_GROUP);
		pair_addr = acx_resolve(b1_ff, WORK_GROUP);
		target    = 8'(dec.cycles * `CLK_PER_CYC);
		sp_pushed = STACK_EXT ? sp_ff - `SP_STEP :
		            {sp_ff[15:8], sp_ff[7:0] - `SP_STEP8};
		alu_go    = (state_ff == S_D2);
		alu_b     = dec.immediate_mode ? b2_ff : RF_RDATA_B;
	end

	always_comb begin
		nxt_state      = state_ff;
		nxt_cnt        = cnt_ff + `CNT_ONE;
		nxt_op         = op_ff;
		nxt_b1         = b1_ff;
		nxt_b2         = b2_ff;
		nxt_dst_eff    = dst_eff_ff;
		nxt_pc         = pc_ff;
		nxt_sp         = sp_ff;
		nxt_flags      = flags_ff;
		nxt_pm_addr    = pm_addr_ff;
		nxt_pm_rd      = 1'b0;
		nxt_rf_raddr_a = rf_raddr_a_ff;
		nxt_rf_raddr_b = rf_raddr_b_ff;
		nxt_rf_rd      = 1'b0;
		nxt_rf_waddr   = rf_waddr_ff;
		nxt_rf_we      = 1'b0;
		nxt_rf_wdata   = rf_wdata_ff;
		nxt_dm_addr    = dm_addr_ff;
		nxt_dm_rd      = 1'b0;
		nxt_dm_we      = 1'b0;
		nxt_dm_wdata   = dm_wdata_ff;
		nxt_done       = 1'b0;
		case (state_ff)
			// Three bytes are always fetched back to back; unused ones are dropped.
			S_F0: begin
				nxt_pm_addr = pc_ff;
				nxt_pm_rd   = 1'b1;
				nxt_state   = S_F1;
			end
			S_F1: begin
				nxt_pm_addr = pc_ff + `ADDR_ONE;
				nxt_pm_rd   = 1'b1;
				nxt_state   = S_F2;
			end
			S_F2: begin
				nxt_pm_addr = pc_ff + `SP_STEP;
				nxt_pm_rd   = 1'b1;
				nxt_op      = PM_RDATA;
				nxt_state   = S_F3;
			end
			S_F3: begin
				nxt_b1    = PM_RDATA;
				nxt_state = S_F4;
			end
			S_F4: begin
				nxt_b2    = PM_RDATA;
				nxt_pc    = pc_ff + {14'h0000, dec.len};
				if (dec.direct_address_mode)
					nxt_state = S_PUSH_HI;
				else if (dec.subroutine_return_op && STACK_EXT)
					nxt_state = S_POP_A;
				else if (dec.add || dec.call_pair || dec.subroutine_return_op)
					nxt_state = S_RD1;
				else
					nxt_state = S_PAD;
			end
			S_RD1: begin
				nxt_rf_rd = 1'b1;
				if (dec.call_pair) begin
					nxt_rf_raddr_a = pair_addr;
					nxt_rf_raddr_b = pair_addr + `ADDR_ONE8;
				end else if (dec.subroutine_return_op) begin
					nxt_rf_raddr_a = sp_ff[7:0];
					nxt_rf_raddr_b = sp_ff[7:0] + `ADDR_ONE8;
				end else begin
					nxt_rf_raddr_a = dst_addr;
					nxt_rf_raddr_b = src_addr;
				end
				nxt_state = S_W1;
			end
			S_W1: nxt_state = S_D1;
			S_D1: begin
				if (dec.call_pair) begin
					nxt_b1    = RF_RDATA_A;
					nxt_b2    = RF_RDATA_B;
					nxt_state = S_PUSH_HI;
				end else if (dec.subroutine_return_op) begin
					nxt_pc    = {RF_RDATA_A, RF_RDATA_B};
					nxt_sp    = {sp_ff[15:8], sp_ff[7:0] + `SP_STEP8};
					nxt_state = S_PAD;
				end else begin
					// Second round fetches through the pointer, or rereads the direct operand.
					nxt_rf_rd      = 1'b1;
					nxt_rf_raddr_a = dec.dst_ind ? RF_RDATA_A : dst_addr;
					nxt_rf_raddr_b = (dec.indirect_working_reg_mode ||
					                  dec.indirect_full_reg_mode) ? RF_RDATA_B : src_addr;
					nxt_dst_eff    = dec.dst_ind ? RF_RDATA_A : dst_addr;
					nxt_state      = S_W2;
				end
			end
			S_W2: nxt_state = S_D2;
			S_D2: nxt_state = S_WR;
			S_WR: begin
				nxt_rf_we    = 1'b1;
				nxt_rf_waddr = dst_eff_ff;
				nxt_rf_wdata = alu_sum;
				nxt_flags    = alu_flg;
				nxt_state    = S_PAD;
			end
			S_PUSH_HI: begin
				nxt_sp = sp_pushed;
				if (STACK_EXT) begin
					nxt_dm_we    = 1'b1;
					nxt_dm_addr  = sp_pushed;
					nxt_dm_wdata = pc_ff[15:8];
				end else begin
					nxt_rf_we    = 1'b1;
					nxt_rf_waddr = sp_pushed[7:0];
					nxt_rf_wdata = pc_ff[15:8];
				end
				nxt_state = S_PUSH_LO;
			end
			S_PUSH_LO: begin
				// The low byte of the return address sits one above the stack top.
				if (STACK_EXT) begin
					nxt_dm_we    = 1'b1;
					nxt_dm_addr  = sp_ff + `ADDR_ONE;
					nxt_dm_wdata = pc_ff[7:0];
				end else begin
					nxt_rf_we    = 1'b1;
					nxt_rf_waddr = sp_ff[7:0] + `ADDR_ONE8;
					nxt_rf_wdata = pc_ff[7:0];
				end
				nxt_pc    = {b1_ff, b2_ff};
				nxt_state = S_PAD;
			end
			S_POP_A: begin
				nxt_dm_rd   = 1'b1;
				nxt_dm_addr = sp_ff;
				nxt_state   = S_POP_B;
			end
			S_POP_B: begin
				nxt_dm_rd   = 1'b1;
				nxt_dm_addr = sp_ff + `ADDR_ONE;
				nxt_state   = S_POP_C;
			end
			S_POP_C: begin
				nxt_b1    = DM_RDATA;
				nxt_state = S_POP_D;
			end
			S_POP_D: begin
				nxt_pc    = {b1_ff, DM_RDATA};
				nxt_sp    = sp_ff + `SP_STEP;
				nxt_state = S_PAD;
			end
			S_PAD: begin
				// Padding makes every instruction last its documented length exactly.
				if (cnt_ff >= target - `CNT_ONE) begin
					nxt_done  = 1'b1;
					nxt_cnt   = `CNT_ZERO;
					nxt_state = S_F0;
				end
			end
			default: begin
				nxt_cnt   = `CNT_ZERO;
				nxt_state = S_F0;
			end
		endcase
	end

	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state_ff      <= S_F0;
			cnt_ff        <= `CNT_ZERO;
			op_ff         <= `BYTE_ZERO;
			b1_ff         <= `BYTE_ZERO;
			b2_ff         <= `BYTE_ZERO;
			dst_eff_ff    <= `BYTE_ZERO;
			pc_ff         <= `PC_RST;
			sp_ff         <= `SP_RST;
			flags_ff      <= '0;
			pm_addr_ff    <= `PC_RST;
			pm_rd_ff      <= 1'b0;
			rf_raddr_a_ff <= `BYTE_ZERO;
			rf_raddr_b_ff <= `BYTE_ZERO;
			rf_rd_ff      <= 1'b0;
			rf_waddr_ff   <= `BYTE_ZERO;
			rf_we_ff      <= 1'b0;
			rf_wdata_ff   <= `BYTE_ZERO;
			dm_addr_ff    <= `SP_RST;
			dm_rd_ff      <= 1'b0;
			dm_we_ff      <= 1'b0;
			dm_wdata_ff   <= `BYTE_ZERO;
			done_ff       <= 1'b0;
		end else begin
			state_ff      <= nxt_state;
			cnt_ff        <= nxt_cnt;
			op_ff         <= nxt_op;
			b1_ff         <= nxt_b1;
			b2_ff         <= nxt_b2;
			dst_eff_ff    <= nxt_dst_eff;
			pc_ff         <= nxt_pc;
			sp_ff         <= nxt_sp;
			flags_ff      <= nxt_flags;
			pm_addr_ff    <= nxt_pm_addr;
			pm_rd_ff      <= nxt_pm_rd;
			rf_raddr_a_ff <= nxt_rf_raddr_a;
			rf_raddr_b_ff <= nxt_rf_raddr_b;
			rf_rd_ff      <= nxt_rf_rd;
			rf_waddr_ff   <= nxt_rf_waddr;
			rf_we_ff      <= nxt_rf_we;
			rf_wdata_ff   <= nxt_rf_wdata;
			dm_addr_ff    <= nxt_dm_addr;
			dm_rd_ff      <= nxt_dm_rd;
			dm_we_ff      <= nxt_dm_we;
			dm_wdata_ff   <= nxt_dm_wdata;
			done_ff       <= nxt_done;
		end
	end

	assign PM_ADDR    = pm_addr_ff;
	assign PM_RD      = pm_rd_ff;
	assign RF_RADDR_A = rf_raddr_a_ff;
	assign RF_RADDR_B = rf_raddr_b_ff;
	assign RF_RD      = rf_rd_ff;
	assign RF_WADDR   = rf_waddr_ff;
	assign RF_WE      = rf_we_ff;
	assign RF_WDATA   = rf_wdata_ff;
	assign DM_ADDR    = dm_addr_ff;
	assign DM_RD      = dm_rd_ff;
	assign DM_WE      = dm_we_ff;
	assign DM_WDATA   = dm_wdata_ff;
	assign PC         = pc_ff;
	assign SP         = sp_ff;
	assign FLAGS      = flags_ff;
	assign INSTR_DONE = done_ff;

endmodule

/* verilog/acx_defines.svh */
// How it works
// - Add stores dst plus src; src untouched.
// - Add-with-carry also adds the carry flag.
// - Carry flag follows carry out of bit seven.
// - Zero flag set when stored result is zero.
// - Sign flag follows result bit seven.
// - Overflow: same-sign operands, opposite-sign result.
// - Half carry from low nibble; decimal flag cleared.
// - Upper nibble Eh selects a working register.
// - Call lowers stack pointer by two first.
// - Call pushes next address, loads target, keeps flags.
// - Indirect call target from a register pair.
// - Return pops two bytes into program counter.
// - Wide stack pointer pushes into external memory.
// - Narrow stack pointer pushes into register file.
// - Add-with-carry uses upper opcode nibble one.
`ifndef ACX_DEFINES_SVH
`define ACX_DEFINES_SVH

`define OP_ADD_NIB          4'h0
`define OP_ADC_NIB          4'h1
`define MODE_WORK_WORK      4'h2
`define MODE_WORK_IND       4'h3
`define MODE_FULL_FULL      4'h4
`define MODE_FULL_IND       4'h5
`define MODE_FULL_IMM       4'h6
`define MODE_IND_IMM        4'h7
`define OP_CALL_DIRECT      8'hd6
`define OP_CALL_PAIR        8'hd4
`define SUBROUTINE_RETURN_OP 8'haf
`define WORK_NIB            4'he
`define SP_STEP             16'h0002
`define SP_STEP8            8'h02
`define ADDR_ONE            16'h0001
`define ADDR_ONE8           8'h01
`define LEN_ONE             2'h1
`define LEN_TWO             2'h2
`define LEN_THREE           2'h3
`define CYC_SHORT           8'h06
`define CYC_LONG            8'h0a
`define CYC_CALL            8'h14
`define CYC_POP             8'h0e
`define CYC_OTHER           8'h06
`define CLK_PER_CYC         8'h02
`define CNT_ONE             8'h01
`define CNT_ZERO            8'h00
`define PC_RST              16'h0000
`define SP_RST              16'h0000
`define BYTE_ZERO           8'h00

`endif

/* verilog/acx_pkg.sv */
package acx_pkg;

	typedef struct packed {
		logic c;
		logic z;
		logic s;
		logic v;
		logic d;
		logic h;
	} acx_flags_s;

	typedef struct packed {
		logic       add;
		logic       adc;
		logic       direct_address_mode;
		logic       call_pair;
		logic       subroutine_return_op;
		logic       nib_regs;
		logic       two_full;
		logic       indirect_working_reg_mode;
		logic       indirect_full_reg_mode;
		logic       dst_ind;
		logic       immediate_mode;
		logic [1:0] len;
		logic [7:0] cycles;
	} acx_dec_s;

	typedef enum logic [4:0] {
		S_F0, S_F1, S_F2, S_F3, S_F4,
		S_RD1, S_W1, S_D1, S_W2, S_D2, S_WR,
		S_PUSH_HI, S_PUSH_LO,
		S_POP_A, S_POP_B, S_POP_C, S_POP_D,
		S_PAD
	} acx_state_e;

endpackage

/* verilog/acx_adder.sv */
`timescale 1ns/100ps
`include "acx_defines.svh"
module acx_adder
	import acx_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Operands
	input  wire logic        go,
	input  wire logic [7:0]  a,
	input  wire logic [7:0]  b,
	input  wire logic        cin,
	// Registered result
	output logic      [7:0]  sum_ff,
	output acx_flags_s       flg_ff
);

	logic [8:0] full;
	logic [4:0] low;
	logic [7:0] nxt_sum;
	acx_flags_s nxt_flg;

	always_comb begin
		full    = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		low     = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		nxt_sum = sum_ff;
		nxt_flg = flg_ff;
		if (go) begin
			nxt_sum   = full[7:0];
			nxt_flg.c = full[8];
			nxt_flg.z = (full[7:0] == `BYTE_ZERO);
			nxt_flg.s = full[7];
			nxt_flg.v = (a[7] == b[7]) && (full[7] != a[7]);
			nxt_flg.d = 1'b0;
			nxt_flg.h = low[4];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sum_ff <= `BYTE_ZERO;
			flg_ff <= '0;
		end else begin
			sum_ff <= nxt_sum;
			flg_ff <= nxt_flg;
		end
	end

endmodule

/* verif/acx_core_asserts.sv */
`timescale 1ns/100ps
`include "acx_defines.svh"
module acx_core_asserts
	import acx_pkg::*;
(
	// Clock and reset
	input wire logic        REF_CLK,
	input wire logic        SYS_RST,
	// Configuration and memory strobes
	input wire logic [3:0]  WORK_GROUP,
	input wire logic        STACK_EXT,
	input wire logic        PM_RD,
	input wire logic [7:0]  PM_RDATA,
	input wire logic [7:0]  RF_RADDR_A,
	input wire logic [7:0]  RF_RADDR_B,
	input wire logic        RF_RD,
	input wire logic [7:0]  RF_WADDR,
	input wire logic        RF_WE,
	input wire logic [7:0]  RF_WDATA,
	input wire logic [15:0] DM_ADDR,
	input wire logic        DM_WE,
	input wire logic [7:0]  DM_WDATA,
	// Core state
	input wire logic [15:0] PC,
	input wire logic [15:0] SP,
	input wire acx_flags_s  FLAGS,
	input wire logic        INSTR_DONE
);
	logic       run_ff;
	logic [7:0] cnt_ff, op_ff, b1_ff, b2_ff;
	logic       call_w, add_w;

	assign call_w = op_ff == `OP_CALL_DIRECT || op_ff == `OP_CALL_PAIR;
	assign add_w = op_ff[7:5] == 3'b000 && op_ff[3:0] inside {[4'h2:4'h7]};

	function automatic logic [7:0] span(input logic [7:0] op);
		logic [7:0] n;
		n = add_w ? (op[3:0] < 4'h4 ? `CYC_SHORT : `CYC_LONG) : `CYC_OTHER;
		if (call_w)
			n = `CYC_CALL;
		if (op == `SUBROUTINE_RETURN_OP)
			n = `CYC_POP;
		return n + n - 8'h02;
	endfunction

	// Counting starts at the first fetch strobe, so reset-release numbering cannot skew it.
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			run_ff <= 1'b0;
			cnt_ff <= 8'h00;
			op_ff  <= 8'h00;
			b1_ff  <= 8'h00;
			b2_ff  <= 8'h00;
		end else begin
			run_ff <= !INSTR_DONE && (run_ff || PM_RD);
			cnt_ff <= (PM_RD && !run_ff) ? 8'h00 : cnt_ff + 8'h01;
			op_ff  <= (run_ff && cnt_ff == 8'h00) ? PM_RDATA : op_ff;
			b1_ff  <= (run_ff && cnt_ff == 8'h01) ? PM_RDATA : b1_ff;
			b2_ff  <= (run_ff && cnt_ff == 8'h02) ? PM_RDATA : b2_ff;
		end
	end

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);

	a_done_len: assert property (INSTR_DONE |-> cnt_ff == span(op_ff))
		else $error("instruction length wrong");
	a_push_pair: assert property ($rose(DM_WE) |-> (STACK_EXT && DM_ADDR == SP
		&& DM_WDATA == PC[15:8]) ##1 (DM_WE && DM_ADDR == SP + 16'h0001
		&& DM_WDATA == $past(PC[7:0]))) else $error("external push wrong");
	a_int_push: assert property ($rose(RF_WE) && call_w |-> (!STACK_EXT
		&& RF_WADDR == SP[7:0] && RF_WDATA == PC[15:8]) ##1 (RF_WE
		&& RF_WADDR == SP[7:0] + 8'h01)) else $error("internal push wrong");
	a_call_sp: assert property (call_w && $changed(SP) |-> SP[7:0]
		== $past(SP[7:0]) - 8'h02) else $error("stack step wrong");
	a_call_target: assert property (op_ff == `OP_CALL_DIRECT && cnt_ff > 8'h03
		&& $changed(PC) |-> PC == {b1_ff, b2_ff}) else $error("call target wrong");
	a_zero_sign: assert property (RF_WE && add_w |-> FLAGS.z == (RF_WDATA == 8'h00)
		&& FLAGS.s == RF_WDATA[7] && !FLAGS.d) else $error("add flags wrong");
	a_flag_cause: assert property ($changed(FLAGS) |-> RF_WE && add_w)
		else $error("flags moved outside add");
	a_work_reg: assert property (RF_RD && cnt_ff == 8'h04 && add_w && op_ff[3:1] == 3'b001
		|-> RF_RADDR_A == {WORK_GROUP, b1_ff[7:4]} && RF_RADDR_B == {WORK_GROUP, b1_ff[3:0]})
		else $error("working register wrong");

	c_call_done: cover property (INSTR_DONE && op_ff == `OP_CALL_PAIR);
	c_ext_push: cover property ($rose(DM_WE));
	c_carry_out: cover property (RF_WE && add_w && FLAGS.c);
endmodule

bind acx_core acx_core_asserts chk (.*);

/* verif/acx_mem_model.sv */
`timescale 1ns/100ps
module acx_mem_model (
	// Clock
	input  wire logic        clk,
	// Program memory
	input  wire logic [15:0] pa,
	input  wire logic        prd,
	output logic      [7:0]  pd,
	// Register file
	input  wire logic [7:0]  ra,
	input  wire logic [7:0]  rb,
	input  wire logic        rrd,
	output logic      [7:0]  rda,
	output logic      [7:0]  rdb,
	input  wire logic [7:0]  wa,
	input  wire logic        rwe,
	input  wire logic [7:0]  wd,
	// Data memory
	input  wire logic [15:0] da,
	input  wire logic        drd,
	input  wire logic        dwe,
	input  wire logic [7:0]  dwd,
	output logic      [7:0]  dd
);
	logic [7:0] pm [0:65535];
	logic [7:0] rf [0:255];
	logic [7:0] dm [0:65535];

	initial begin
		pd = 8'h00;
		rda = 8'h00;
		rdb = 8'h00;
		dd = 8'h00;
	end

	// Read data holds only in the cycle after a strobe; otherwise it flips so late sampling shows.
	always @(posedge clk) begin
		pd <= prd ? pm[pa] : ~pd;
		rda <= rrd ? rf[ra] : ~rda;
		rdb <= rrd ? rf[rb] : ~rdb;
		dd <= drd ? dm[da] : ~dd;
		if (rwe)
			rf[wa] <= wd;
		if (dwe)
			dm[da] <= dwd;
	end
endmodule

/* verif/acx_core_test.sv */
`timescale 1ns/100ps
`include "acx_defines.svh"
module acx_core_test;
	import acx_pkg::*;

	logic        clk, rst, ext, prd, rrd, rwe, drd, dwe, done;
	logic [3:0]  wg;
	logic [7:0]  pd, ra, rb, rda, rdb, wa, wd, dwd, dd;
	logic [15:0] pa, da, pc, sp, pc_e, sp_e;
	logic [30:0] seen;
	logic [30:0] q[$];
	logic [15:0] stk[$];
	acx_flags_s  flags, fl;
	integer      seed = 32'hd95cfcaf;
	int          bad_count = 0, check_count = 0, cycles = 0;

	acx_core dut (.REF_CLK(clk), .SYS_RST(rst), .WORK_GROUP(wg), .STACK_EXT(ext),
		.PM_ADDR(pa), .PM_RD(prd), .PM_RDATA(pd), .RF_RADDR_A(ra), .RF_RADDR_B(rb),
		.RF_RD(rrd), .RF_RDATA_A(rda), .RF_RDATA_B(rdb), .RF_WADDR(wa), .RF_WE(rwe),
		.RF_WDATA(wd), .DM_ADDR(da), .DM_RD(drd), .DM_WE(dwe), .DM_WDATA(dwd),
		.DM_RDATA(dd), .PC(pc), .SP(sp), .FLAGS(flags), .INSTR_DONE(done));
	acx_mem_model mem (.*);

	assign seen = {dwe, dwe ? da : {8'h00, wa}, dwe ? dwd : wd, flags};

	task automatic check(input string what, input logic [30:0] got, input logic [30:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	function automatic logic [7:0] rs(input logic [7:0] x);
		return (x[7:4] == 4'he) ? {wg, x[3:0]} : x;
	endfunction

	// Notes the writes an instruction must make, then waits for its completion pulse.
	task automatic run(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2);
		logic [7:0]  a, b, d;
		logic [8:0]  s;
		logic [4:0]  h;
		logic [15:0] w;
		int          n;
		int          c;
		mem.pm[pc_e] = op;
		mem.pm[pc_e + 16'h0001] = b1;
		mem.pm[pc_e + 16'h0002] = b2;
		c = (op == `OP_CALL_DIRECT || op == `OP_CALL_PAIR) ? `CYC_CALL :
		    (op == `SUBROUTINE_RETURN_OP) ? `CYC_POP : `CYC_OTHER;
		if (op[7:5] == 3'b000 && op[3:0] inside {[4'h2:4'h7]}) begin
			for (n = 0; n < 256; n++)
				mem.rf[n] = 8'($random(seed));
			d = (op[3:0] < 4'h4) ? {wg, b1[7:4]} : (op[3:0] < 4'h6) ? rs(b2) : rs(b1);
			d = (op[3:0] == 4'h7) ? mem.rf[d] : d;
			b = (op[3:0] < 4'h4) ? {wg, b1[3:0]} : rs(b1);
			b = (op[3:0] == 4'h3 || op[3:0] == 4'h5) ? mem.rf[b] : b;
			b = (op[3:0] > 4'h5) ? b2 : mem.rf[b];
			a = mem.rf[d];
			s = {1'b0, a} + {1'b0, b} + {8'h00, op[4] & fl.c};
			h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, op[4] & fl.c};
			fl = '{s[8], s[7:0] == 8'h00, s[7], a[7] == b[7] && s[7] != a[7], 1'b0, h[4]};
			q.push_back({1'b0, 8'h00, d, s[7:0], fl});
			pc_e = pc_e + ((op[3:0] < 4'h4) ? 16'h0002 : 16'h0003);
			c = (op[3:0] < 4'h4) ? `CYC_SHORT : `CYC_LONG;
		end else if (op == `OP_CALL_DIRECT || op == `OP_CALL_PAIR) begin
			stk.push_back(pc_e + ((op == `OP_CALL_DIRECT) ? 16'h0003 : 16'h0002));
			pc_e = (op == `OP_CALL_DIRECT) ? {b1, b2} : {mem.rf[rs(b1)], mem.rf[rs(b1) + 8'h01]};
			sp_e = ext ? sp_e - 16'h0002 : {sp_e[15:8], sp_e[7:0] - 8'h02};
			w = ext ? sp_e : {8'h00, sp_e[7:0]};
			q.push_back({ext, w, stk[$][15:8], fl});
			q.push_back({ext, ext ? w + 16'h0001 : {8'h00, w[7:0] + 8'h01}, stk[$][7:0], fl});
		end else if (op == `SUBROUTINE_RETURN_OP) begin
			pc_e = stk.pop_back();
			sp_e = ext ? sp_e + 16'h0002 : {sp_e[15:8], sp_e[7:0] + 8'h02};
		end else
			pc_e = pc_e + 16'h0001;
		// The completion pulse is read one step after the edge that launches it.
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (done !== 1'b1 && n < 100);
		check("done", 31'(n < 100), 31'h1);
		check("cycles", 31'(n), 31'(c * `CLK_PER_CYC));
		check("pc", 31'(pc), 31'(pc_e));
		check("sp", 31'(sp), 31'(sp_e));
		check("flags", 31'(flags), 31'(fl));
	endtask

	// Each memory write is matched against the oldest noted write.
	always @(negedge clk) begin
		if (!rst && (rwe || dwe))
			check("write", seen, (q.size() > 0) ? q.pop_front() : 31'bx);
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			close_out();
		end
	end

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		int k;
		rst = 1'b1;
		ext = 1'b1;
		wg = 4'h0;
		pc_e = 16'h0000;
		sp_e = 16'h0000;
		fl = '0;
		repeat (6) @(posedge clk);
		#1;
		check("reset pc", 31'(pc), 31'h0);
		check("reset sp flags", 31'({sp, flags}), 31'h0);
		rst = 1'b0;
		for (k = 0; k < 72; k++) begin
			wg = 4'($random(seed));
			run({3'b000, k[0], 4'h2 + 4'((k / 2) % 6)}, 8'($random(seed)), 8'($random(seed)));
		end
		for (k = 0; k < 2; k++) begin
			ext = (k == 0);
			run(`OP_CALL_DIRECT, 8'($random(seed)), 8'($random(seed)));
			run(`SUBROUTINE_RETURN_OP, 8'h00, 8'h00);
			run(`OP_CALL_PAIR, 8'he4, 8'h00);
			run(`OP_CALL_PAIR, 8'($random(seed)), 8'h00);
			run(`SUBROUTINE_RETURN_OP, 8'h00, 8'h00);
			run(`SUBROUTINE_RETURN_OP, 8'h00, 8'h00);
			run(8'hff, 8'h00, 8'h00);
		end
		check("writes left", 31'(q.size()), 31'h0);
		close_out();
	end
endmodule
